//--- ilc_pkg.sv
// interleaved converter trigger control: shared constants and types
// --------------------------------------------------------------------
// Functional notes
// - each unit offers 12, 10 or 8 bit results, speed against precision
// - unit 0 has 13 channels, unit 1 has 16 plus temperature and reference
// - single scan converts selected channels once, lowest first, then stops
// - continuous scan repeats the ascending sequence without new triggers
// - group scan splits channels into groups A and B, each ascending
// - conversion takes 0.4 us per channel at a 50 MHz conversion clock
// - compare-match-A starts unit 0, overflow starts unit 1, continuous
// - scan-end event is always produced, whether or not interrupts enabled
// - unit 0 scan end requests first DMA channel, unit 1 the second
// - interleave works on channel pairs 0, 1 and 2 of both units
// - both units convert the same pin alternately, doubling sample rate
// --------------------------------------------------------------------
package ilc_pkg;

	// ----------------------------------------------------------------
	// widths
	// ----------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int CODE_W = 12;
	localparam int CH_W   = 5;
	localparam int MASK_W = 18;
	localparam int CNT_W  = 10;

	// ----------------------------------------------------------------
	// register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [ADDR_W-1:0] OFS_CTRL    = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_CHSEL0  = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_CHSEL1  = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_GRPB0   = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_GRPB1   = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_SSC     = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_STATUS  = 8'h18;
	localparam logic [ADDR_W-1:0] OFS_RESULT0 = 8'h1C;
	localparam logic [ADDR_W-1:0] OFS_RESULT1 = 8'h20;

	// ----------------------------------------------------------------
	// control fields and reset values
	// ----------------------------------------------------------------
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_RES_LSB  = 2;
	localparam int CTRL_IL_BIT   = 4;
	localparam int CTRL_PAIR_LSB = 5;
	localparam logic [1:0] MAX_PAIR = 2'h2;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] SSC_RESET  = 8'h0B;
	localparam logic [MASK_W-1:0] CHSEL_RESET = 18'h00001;
	localparam logic [MASK_W-1:0] U0_MASK = 18'h01FFF;
	localparam logic [MASK_W-1:0] U1_MASK = 18'h3FFFF;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_MHZ       = 100;
	localparam int CONV_CLK_MHZ  = 50;
	localparam int CONV_TIME_NS  = 400;
	localparam int CONV_CYC      = CONV_TIME_NS * CLK_MHZ / 1000;
	localparam int CLK_PER_STATE = CLK_MHZ / CONV_CLK_MHZ;
	localparam int HALF_CYC      = CLK_PER_STATE / 2;
	localparam int SAR_OVH       = CONV_CYC - CODE_W - HALF_CYC
		- int'(SSC_RESET) * CLK_PER_STATE;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		MODE_SINGLE,
		MODE_CONT,
		MODE_GROUP
	} ilc_mode_e;

	typedef enum logic [1:0] {
		PH_IDLE,
		PH_SAMPLE,
		PH_CONV
	} ilc_phase_e;

	typedef struct packed {
		ilc_phase_e        ph;
		logic [CH_W-1:0]   ch;
		logic [CNT_W-1:0]  cnt;
		logic              grp;
		logic [CODE_W-1:0] res;
		logic [CH_W-1:0]   res_ch;
		logic              hold;
		logic              done;
	} ilc_unit_s;

endpackage : ilc_pkg

//--- ilc_top.sv
// interleaved converter trigger control: sequencers and register slave
//
// Design decisions made here: register access over AXI4-Lite and the register offsets.
`timescale 1ns/100ps
module ilc_top (
	input  wire logic                         CLOCK,
	input  wire logic                         RESET_N,
	input  wire logic                         TRIG_0,
	input  wire logic                         TRIG_1,
	input  wire logic [ilc_pkg::CODE_W-1:0]   CODE_0,
	input  wire logic [ilc_pkg::CODE_W-1:0]   CODE_1,
	output logic      [ilc_pkg::CH_W-1:0]     CH_SEL_0,
	output logic      [ilc_pkg::CH_W-1:0]     CH_SEL_1,
	output logic                              HOLD_0,
	output logic                              HOLD_1,
	output logic                              SHARED_PIN_LINK,
	output logic                              FIRST_DMA_REQ,
	output logic                              SECOND_DMA_REQ,
	input  wire logic                         S_AXI_AWVALID,
	output logic                              S_AXI_AWREADY,
	input  wire logic [ilc_pkg::ADDR_W-1:0]   S_AXI_AWADDR,
	input  wire logic                         S_AXI_WVALID,
	output logic                              S_AXI_WREADY,
	input  wire logic [ilc_pkg::DATA_W-1:0]   S_AXI_WDATA,
	input  wire logic [3:0]                   S_AXI_WSTRB,
	output logic                              S_AXI_BVALID,
	input  wire logic                         S_AXI_BREADY,
	output logic      [1:0]                   S_AXI_BRESP,
	input  wire logic                         S_AXI_ARVALID,
	output logic                              S_AXI_ARREADY,
	input  wire logic [ilc_pkg::ADDR_W-1:0]   S_AXI_ARADDR,
	output logic                              S_AXI_RVALID,
	input  wire logic                         S_AXI_RREADY,
	output logic      [ilc_pkg::DATA_W-1:0]   S_AXI_RDATA,
	output logic      [1:0]                   S_AXI_RRESP
);
	import ilc_pkg::*;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [1:0]                   trig_s1;
		logic [1:0]                   trig_s2;
		logic [1:0]                   trig_p;
		logic [1:0][CODE_W-1:0]       code_s1;
		logic [1:0][CODE_W-1:0]       code_s2;
		logic                         aw_have;
		logic                         w_have;
		logic                         awready;
		logic                         wready;
		logic                         bvalid;
		logic [1:0]                   bresp;
		logic [ADDR_W-1:0]            awaddr;
		logic [DATA_W-1:0]            wdata;
		logic [3:0]                   wstrb;
		logic                         arready;
		logic                         rvalid;
		logic [1:0]                   rresp;
		logic [DATA_W-1:0]            rdata;
		logic [7:0]                   ctrl;
		logic [7:0]                   ssc;
		logic [1:0][MASK_W-1:0]       chsel;
		logic [1:0][MASK_W-1:0]       grpb;
		logic                         share;
		ilc_unit_s [1:0]              u;
	} ilc_state_s;

	ilc_state_s q;
	ilc_state_s n;
	logic [1:0] rst_sync_q;
	logic       rst_n;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [CH_W:0] first_ch(
		input logic [MASK_W-1:0] m,
		input logic [CH_W:0]     from
	);
		logic [CH_W:0] r;
		r = '0;
		for (int i = MASK_W - 1; i >= 0; i--) begin
			if (m[i] && (6'(i) >= from)) begin
				r = {1'b1, CH_W'(i)};
			end
		end
		return r;
	endfunction : first_ch

	function automatic logic [3:0] res_bits(input logic [1:0] r);
		case (r)
			2'h1:    return 4'hA;
			2'h2:    return 4'h8;
			default: return 4'hC;
		endcase
	endfunction : res_bits

	// lower resolutions drop the low bits, right-aligned in the result
	function automatic logic [CODE_W-1:0] scale(
		input logic [CODE_W-1:0] c,
		input logic [1:0]        r
	);
		case (r)
			2'h1:    return {2'h0, c[11:2]};
			2'h2:    return {4'h0, c[11:4]};
			default: return c;
		endcase
	endfunction : scale

	function automatic logic [CNT_W-1:0] samp_load(input logic [7:0] s);
		return CNT_W'(s) * CNT_W'(CLK_PER_STATE) + CNT_W'(HALF_CYC)
			- CNT_W'(1);
	endfunction : samp_load

	function automatic logic [CNT_W-1:0] conv_load(input logic [1:0] r);
		return CNT_W'(res_bits(r)) + CNT_W'(SAR_OVH) - CNT_W'(1);
	endfunction : conv_load

	function automatic logic [DATA_W-1:0] wmerge(
		input logic [DATA_W-1:0] old,
		input logic [DATA_W-1:0] d,
		input logic [3:0]        s
	);
		logic [DATA_W-1:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (s[b]) begin
				r[b*8 +: 8] = d[b*8 +: 8];
			end
		end
		return r;
	endfunction : wmerge

	function automatic logic [ADDR_W-1:0] word(input logic [ADDR_W-1:0] a);
		return {a[ADDR_W-1:2], 2'h0};
	endfunction : word

	// ----------------------------------------------------------------
	// reset release
	// ----------------------------------------------------------------
	always_ff @(posedge CLOCK or negedge RESET_N) begin
		if (!RESET_N) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		ilc_mode_e          md;
		logic               il;
		logic [1:0]         pair;
		logic [MASK_W-1:0]  pm;
		logic [MASK_W-1:0]  m;
		logic [CH_W:0]      f;
		logic               t;
		logic               g;
		md   = ilc_mode_e'(q.ctrl[CTRL_MODE_LSB +: 2]);
		il   = q.ctrl[CTRL_IL_BIT];
		pair = q.ctrl[CTRL_PAIR_LSB +: 2];
		pm   = '0;
		m    = '0;
		f    = '0;
		t    = 1'b0;
		g    = 1'b0;
		n    = q;

		// pins cross in through two flops each
		n.trig_s1    = {TRIG_1, TRIG_0};
		n.trig_s2    = q.trig_s1;
		n.trig_p     = q.trig_s2;
		n.code_s1[0] = CODE_0;
		n.code_s1[1] = CODE_1;
		n.code_s2    = q.code_s1;

		// ------------------------------------------------------------
		// write channel: address and data taken in either order
		// ------------------------------------------------------------
		if (S_AXI_AWVALID && q.awready) begin
			n.aw_have = 1'b1;
			n.awaddr  = S_AXI_AWADDR;
		end
		if (S_AXI_WVALID && q.wready) begin
			n.w_have = 1'b1;
			n.wdata  = S_AXI_WDATA;
			n.wstrb  = S_AXI_WSTRB;
		end
		if (q.bvalid && S_AXI_BREADY) begin
			n.bvalid = 1'b0;
		end
		if (q.aw_have && q.w_have && !q.bvalid) begin
			n.aw_have = 1'b0;
			n.w_have  = 1'b0;
			n.bvalid  = 1'b1;
			n.bresp   = RESP_OKAY;
			case (word(q.awaddr))
				OFS_CTRL: begin
					n.ctrl = 8'(wmerge(32'(q.ctrl), q.wdata, q.wstrb));
				end
				OFS_CHSEL0: begin
					n.chsel[0] = U0_MASK & MASK_W'(wmerge(
						32'(q.chsel[0]), q.wdata, q.wstrb));
				end
				OFS_CHSEL1: begin
					n.chsel[1] = U1_MASK & MASK_W'(wmerge(
						32'(q.chsel[1]), q.wdata, q.wstrb));
				end
				OFS_GRPB0: begin
					n.grpb[0] = U0_MASK & MASK_W'(wmerge(
						32'(q.grpb[0]), q.wdata, q.wstrb));
				end
				OFS_GRPB1: begin
					n.grpb[1] = U1_MASK & MASK_W'(wmerge(
						32'(q.grpb[1]), q.wdata, q.wstrb));
				end
				OFS_SSC: begin
					n.ssc = 8'(wmerge(32'(q.ssc), q.wdata, q.wstrb));
				end
				OFS_STATUS, OFS_RESULT0, OFS_RESULT1: begin
				end
				default: begin
					n.bresp = RESP_SLVERR;
				end
			endcase
		end
		n.awready = !n.aw_have && !n.bvalid;
		n.wready  = !n.w_have && !n.bvalid;

		// ------------------------------------------------------------
		// read channel
		// ------------------------------------------------------------
		if (q.rvalid && S_AXI_RREADY) begin
			n.rvalid = 1'b0;
		end
		if (S_AXI_ARVALID && q.arready) begin
			n.rvalid = 1'b1;
			n.rresp  = RESP_OKAY;
			n.rdata  = '0;
			case (word(S_AXI_ARADDR))
				OFS_CTRL:   n.rdata = 32'(q.ctrl);
				OFS_CHSEL0: n.rdata = 32'(q.chsel[0]);
				OFS_CHSEL1: n.rdata = 32'(q.chsel[1]);
				OFS_GRPB0:  n.rdata = 32'(q.grpb[0]);
				OFS_GRPB1:  n.rdata = 32'(q.grpb[1]);
				OFS_SSC:    n.rdata = 32'(q.ssc);
				OFS_STATUS: begin
					n.rdata = {11'h0, q.u[1].ch, 3'h0, q.u[0].ch, 4'h0,
						q.u[1].grp, q.u[0].grp,
						q.u[1].ph != PH_IDLE, q.u[0].ph != PH_IDLE};
				end
				// the first DMA channel reads this one
				OFS_RESULT0: begin
					n.rdata = {11'h0, q.u[0].res_ch, 4'h0, q.u[0].res};
				end
				// the second DMA channel reads this one
				OFS_RESULT1: begin
					n.rdata = {11'h0, q.u[1].res_ch, 4'h0, q.u[1].res};
				end
				default: begin
					n.rresp = RESP_SLVERR;
				end
			endcase
		end
		n.arready = !n.rvalid;

		// ------------------------------------------------------------
		// interleave: both units on one pin, pair 0, 1 or 2
		// ------------------------------------------------------------
		if (pair > MAX_PAIR) begin
			pair = 2'h0;
		end
		pm      = MASK_W'(1) << pair;
		n.share = il;

		// ------------------------------------------------------------
		// unit sequencers; unit 0 on TRIG_0, unit 1 on TRIG_1
		// ------------------------------------------------------------
		for (int k = 0; k < 2; k++) begin
			// triggers landing mid-scan are dropped, so spacing is
			// the timer's job
			t = q.trig_s2[k] && !q.trig_p[k];
			g = (md == MODE_GROUP) && q.u[k].grp && !il;
			m = il ? pm : (g ? q.grpb[k] : q.chsel[k]);
			n.u[k].done = 1'b0;
			case (q.u[k].ph)
				PH_IDLE: begin
					f = first_ch(m, '0);
					if (t && f[CH_W]) begin
						n.u[k].ph   = PH_SAMPLE;
						n.u[k].ch   = f[CH_W-1:0];
						n.u[k].cnt  = samp_load(q.ssc);
						n.u[k].hold = 1'b1;
					end else if (t && md == MODE_GROUP) begin
						// an empty group is skipped
						n.u[k].grp = !q.u[k].grp;
					end
				end
				PH_SAMPLE: begin
					if (q.u[k].cnt == '0) begin
						n.u[k].ph   = PH_CONV;
						n.u[k].cnt  = conv_load(q.ctrl[CTRL_RES_LSB +: 2]);
						n.u[k].hold = 1'b0;
					end else begin
						n.u[k].cnt = q.u[k].cnt - CNT_W'(1);
					end
				end
				PH_CONV: begin
					if (q.u[k].cnt != '0) begin
						n.u[k].cnt = q.u[k].cnt - CNT_W'(1);
					end else begin
						n.u[k].res = scale(q.code_s2[k],
							q.ctrl[CTRL_RES_LSB +: 2]);
						n.u[k].res_ch = q.u[k].ch;
						f = first_ch(m, {1'b0, q.u[k].ch} + 6'h01);
						if (f[CH_W]) begin
							n.u[k].ph   = PH_SAMPLE;
							n.u[k].ch   = f[CH_W-1:0];
							n.u[k].cnt  = samp_load(q.ssc);
							n.u[k].hold = 1'b1;
						end else begin
							// raised with no interrupt enable at all
							n.u[k].done = 1'b1;
							f = first_ch(m, '0);
							if (md == MODE_CONT && f[CH_W]) begin
								n.u[k].ph   = PH_SAMPLE;
								n.u[k].ch   = f[CH_W-1:0];
								n.u[k].cnt  = samp_load(q.ssc);
								n.u[k].hold = 1'b1;
							end else begin
								n.u[k].ph = PH_IDLE;
								if (md == MODE_GROUP) begin
									n.u[k].grp = !q.u[k].grp;
								end
							end
						end
					end
				end
				default: begin
					n.u[k].ph = PH_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge CLOCK or negedge rst_n) begin
		if (!rst_n) begin
			q          <= '0;
			q.ctrl     <= CTRL_RESET;
			q.ssc      <= SSC_RESET;
			q.chsel    <= {CHSEL_RESET, CHSEL_RESET};
			q.awready  <= 1'b1;
			q.wready   <= 1'b1;
			q.arready  <= 1'b1;
		end else begin
			q <= n;
		end
	end

	// ----------------------------------------------------------------
	// outputs, all straight from flops
	// ----------------------------------------------------------------
	assign CH_SEL_0        = q.u[0].ch;
	assign CH_SEL_1        = q.u[1].ch;
	assign HOLD_0          = q.u[0].hold;
	assign HOLD_1          = q.u[1].hold;
	assign SHARED_PIN_LINK = q.share;
	assign FIRST_DMA_REQ   = q.u[0].done;
	assign SECOND_DMA_REQ  = q.u[1].done;
	assign S_AXI_AWREADY   = q.awready;
	assign S_AXI_WREADY    = q.wready;
	assign S_AXI_BVALID    = q.bvalid;
	assign S_AXI_BRESP     = q.bresp;
	assign S_AXI_ARREADY   = q.arready;
	assign S_AXI_RVALID    = q.rvalid;
	assign S_AXI_RDATA     = q.rdata;
	assign S_AXI_RRESP     = q.rresp;

endmodule : ilc_top

//--- ilc_timer_dma.sv
// trigger timer and dma mover standing beside the converter block
`timescale 1ns/100ps
module ilc_timer_dma (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic start,
	input  wire logic periodic,
	input  wire logic dma_req_0,
	input  wire logic dma_req_1,
	output logic      trig_0,
	output logic      trig_1,
	output int        moved,
	output logic      order_err
);
	// half period 40 cycles: above sample time plus 2 states
	// a full period also covers a one-channel single scan
	localparam int PERIOD = 80;
	localparam int PULSE  = 4;
	int   cnt;
	logic run;
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			run <= 1'b0;
			cnt <= 0;
			trig_0 <= 1'b0;
			trig_1 <= 1'b0;
			moved <= 0;
			order_err <= 1'b0;
		end else begin
			if (start) begin
				run <= 1'b1;
				cnt <= 0;
				moved <= 0;
				order_err <= 1'b0;
			end else if (run) begin
				cnt <= cnt + 1;
				if (cnt == PERIOD - 1) begin
					cnt <= 0;
					run <= periodic;
				end
			end
			trig_0 <= run && cnt >= PERIOD / 2
				&& cnt < PERIOD / 2 + PULSE;
			trig_1 <= run && cnt >= PERIOD - PULSE;
			// one shared buffer: unit 0 even slots, unit 1 odd
			if (dma_req_0 || dma_req_1) begin
				moved <= moved + 1;
				if (dma_req_0 ? moved[0] : !moved[0])
					order_err <= 1'b1;
			end
		end
	end
endmodule : ilc_timer_dma

//--- ilc_top_asserts.sv
// port-level timing properties of the converter block
`timescale 1ns/100ps
module ilc_top_asserts
	import ilc_pkg::*;
(
	input wire logic                       CLOCK,
	input wire logic                       RESET_N,
	input wire logic                       HOLD_0,
	input wire logic                       HOLD_1,
	input wire logic [ilc_pkg::CH_W-1:0]   CH_SEL_0,
	input wire logic [ilc_pkg::CH_W-1:0]   CH_SEL_1,
	input wire logic                       SHARED_PIN_LINK,
	input wire logic                       FIRST_DMA_REQ,
	input wire logic                       SECOND_DMA_REQ,
	input wire logic                       S_AXI_AWVALID,
	input wire logic                       S_AXI_AWREADY,
	input wire logic                       S_AXI_WVALID,
	input wire logic                       S_AXI_WREADY,
	input wire logic                       S_AXI_BVALID,
	input wire logic                       S_AXI_BREADY,
	input wire logic [1:0]                 S_AXI_BRESP,
	input wire logic                       S_AXI_ARVALID,
	input wire logic                       S_AXI_ARREADY,
	input wire logic                       S_AXI_RVALID,
	input wire logic                       S_AXI_RREADY,
	input wire logic [ilc_pkg::DATA_W-1:0] S_AXI_RDATA
);
	// bench keeps the reset state count, so sampling is fixed
	localparam int HOLD_CYC = 2 * int'(SSC_RESET) + 1;
	logic [7:0] h0_q;
	logic [7:0] h1_q;
	always_ff @(posedge CLOCK or negedge RESET_N) begin
		if (!RESET_N) begin
			h0_q <= 8'h00;
			h1_q <= 8'h00;
		end else begin
			h0_q <= HOLD_0 ? h0_q + 8'h01 : 8'h00;
			h1_q <= HOLD_1 ? h1_q + 8'h01 : 8'h00;
		end
	end
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!RESET_N);
	a_dma0_pulse: assert property (FIRST_DMA_REQ |=> !FIRST_DMA_REQ[*8])
		else $error("first dma request not a lone pulse");
	a_dma1_pulse: assert property (SECOND_DMA_REQ |=> !SECOND_DMA_REQ[*8])
		else $error("second dma request not a lone pulse");
	a_hold0_len: assert property ($fell(HOLD_0) |-> h0_q == HOLD_CYC)
		else $error("unit 0 sampling length wrong");
	a_hold1_len: assert property ($fell(HOLD_1) |-> h1_q == HOLD_CYC)
		else $error("unit 1 sampling length wrong");
	a_conv_gap: assert property ($fell(HOLD_0) |-> !FIRST_DMA_REQ[*8])
		else $error("scan end too soon after sampling");
	a_ch_steady: assert property (HOLD_0 && $past(HOLD_0) |-> $stable(CH_SEL_0))
		else $error("channel moved while sampling");
	a_pair_unit0: assert property (SHARED_PIN_LINK && HOLD_0 |-> CH_SEL_0 <= 5'h02)
		else $error("unit 0 off the interleave pair");
	a_pair_unit1: assert property (SHARED_PIN_LINK && HOLD_1 |-> CH_SEL_1 <= 5'h02)
		else $error("unit 1 off the interleave pair");
	a_bresp_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY
		|=> S_AXI_BVALID && $stable(S_AXI_BRESP))
		else $error("write response dropped early");
	a_rdata_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY
		|=> S_AXI_RVALID && $stable(S_AXI_RDATA))
		else $error("read data dropped early");
	a_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY
		|=> S_AXI_RVALID && !S_AXI_ARREADY)
		else $error("read answer late");
	a_write_answer: assert property (S_AXI_AWVALID && S_AXI_AWREADY
		&& S_AXI_WVALID && S_AXI_WREADY |-> ##[1:2] S_AXI_BVALID)
		else $error("write answer late");
endmodule : ilc_top_asserts
bind ilc_top ilc_top_asserts u_ilc_top_asserts (.CLOCK(CLOCK),
	.RESET_N(RESET_N), .HOLD_0(HOLD_0), .HOLD_1(HOLD_1),
	.CH_SEL_0(CH_SEL_0), .CH_SEL_1(CH_SEL_1),
	.SHARED_PIN_LINK(SHARED_PIN_LINK), .FIRST_DMA_REQ(FIRST_DMA_REQ),
	.SECOND_DMA_REQ(SECOND_DMA_REQ), .S_AXI_AWVALID(S_AXI_AWVALID),
	.S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID),
	.S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BVALID(S_AXI_BVALID),
	.S_AXI_BREADY(S_AXI_BREADY), .S_AXI_BRESP(S_AXI_BRESP),
	.S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
	.S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
	.S_AXI_RDATA(S_AXI_RDATA));

//--- ilc_top_test.sv
// self-checking bench for the interleaved converter block
`timescale 1ns/100ps
module ilc_top_test;
	import ilc_pkg::*;
	logic CLOCK, RESET_N, TRIG_0, TRIG_1, HOLD_0, HOLD_1, SHARED_PIN_LINK;
	logic FIRST_DMA_REQ, SECOND_DMA_REQ, start, periodic, order_err;
	logic [CODE_W-1:0] CODE_0, CODE_1;
	logic [CH_W-1:0]   CH_SEL_0, CH_SEL_1;
	logic S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY;
	logic S_AXI_BVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY;
	logic S_AXI_RVALID, S_AXI_RREADY;
	logic [ADDR_W-1:0] S_AXI_AWADDR, S_AXI_ARADDR;
	logic [DATA_W-1:0] S_AXI_WDATA, S_AXI_RDATA, d;
	logic [3:0]        S_AXI_WSTRB;
	logic [1:0]        S_AXI_BRESP, S_AXI_RRESP, r;
	logic [CH_W-1:0]   chs[$];
	int error_cnt, checked, moved, span, h;
	ilc_top u_ilc_top (.CLOCK(CLOCK), .RESET_N(RESET_N), .TRIG_0(TRIG_0),
		.TRIG_1(TRIG_1), .CODE_0(CODE_0), .CODE_1(CODE_1),
		.CH_SEL_0(CH_SEL_0), .CH_SEL_1(CH_SEL_1), .HOLD_0(HOLD_0),
		.HOLD_1(HOLD_1), .SHARED_PIN_LINK(SHARED_PIN_LINK),
		.FIRST_DMA_REQ(FIRST_DMA_REQ), .SECOND_DMA_REQ(SECOND_DMA_REQ),
		.S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
		.S_AXI_AWADDR(S_AXI_AWADDR), .S_AXI_WVALID(S_AXI_WVALID),
		.S_AXI_WREADY(S_AXI_WREADY), .S_AXI_WDATA(S_AXI_WDATA),
		.S_AXI_WSTRB(S_AXI_WSTRB), .S_AXI_BVALID(S_AXI_BVALID),
		.S_AXI_BREADY(S_AXI_BREADY), .S_AXI_BRESP(S_AXI_BRESP),
		.S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
		.S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_RVALID(S_AXI_RVALID),
		.S_AXI_RREADY(S_AXI_RREADY), .S_AXI_RDATA(S_AXI_RDATA),
		.S_AXI_RRESP(S_AXI_RRESP));
	ilc_timer_dma u_ilc_timer_dma (.clk(CLOCK), .rst_n(RESET_N),
		.start(start), .periodic(periodic), .dma_req_0(FIRST_DMA_REQ),
		.dma_req_1(SECOND_DMA_REQ), .trig_0(TRIG_0), .trig_1(TRIG_1),
		.moved(moved), .order_err(order_err));
	initial begin
		CLOCK = 1'b0;
		forever #5 CLOCK = ~CLOCK;
	end
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			error_cnt++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
		int n = 0;
		@(posedge CLOCK);
		S_AXI_AWVALID <= 1'b1;
		S_AXI_WVALID <= 1'b1;
		S_AXI_AWADDR <= a;
		S_AXI_WDATA <= v;
		S_AXI_BREADY <= 1'b1;
		do begin
			@(posedge CLOCK);
			n++;
			if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
			if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
		end while (!S_AXI_BVALID && n < 50);
		r = S_AXI_BRESP;
		S_AXI_BREADY <= 1'b0;
		chk("write done", 1, n < 50);
	endtask : axi_wr
	task automatic axi_rd(input logic [7:0] a);
		int n = 0;
		@(posedge CLOCK);
		S_AXI_ARVALID <= 1'b1;
		S_AXI_ARADDR <= a;
		S_AXI_RREADY <= 1'b1;
		do begin
			@(posedge CLOCK);
			n++;
			if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
		end while (!S_AXI_RVALID && n < 50);
		d = S_AXI_RDATA;
		r = S_AXI_RRESP;
		S_AXI_RREADY <= 1'b0;
		chk("read done", 1, n < 50);
	endtask : axi_rd
	// fires the timer once; logs unit 0 channels until n scan ends
	task automatic run0(input int n);
		int t = 0;
		int k = 0;
		logic hp = 1'b0;
		chs.delete();
		span = 0;
		@(posedge CLOCK);
		start <= 1'b1;
		@(posedge CLOCK);
		start <= 1'b0;
		while (k < n && t < 3000) begin
			@(posedge CLOCK);
			t++;
			if (HOLD_0 && !hp) chs.push_back(CH_SEL_0);
			if (chs.size() > 0) span++;
			if (FIRST_DMA_REQ) k++;
			hp = HOLD_0;
		end
		chk("scan ends", n, k);
	endtask : run0
	task automatic idle0();
		h = 0;
		repeat (150) begin
			@(posedge CLOCK);
			if (HOLD_0) h++;
		end
	endtask : idle0
	task automatic t_regs();
		axi_rd(OFS_SSC); chk("ssc", 32'h0000000B, d);
		axi_rd(OFS_CHSEL0); chk("chsel0", 32'h00000001, d);
		axi_wr(OFS_CHSEL0, 32'hFFFFFFFF);
		axi_rd(OFS_CHSEL0); chk("chsel0 mask", 32'h00001FFF, d);
		axi_wr(OFS_CHSEL1, 32'h00030000);
		axi_rd(OFS_CHSEL1); chk("chsel1", 32'h00030000, d);
		axi_wr(8'h40, 32'h00000001); chk("bad write", RESP_SLVERR, r);
		axi_rd(8'h40); chk("bad read", RESP_SLVERR, r);
	endtask : t_regs
	task automatic t_res();
		axi_wr(OFS_CHSEL0, 32'h00000001);
		for (int k = 2; k >= 0; k--) begin
			axi_wr(OFS_CTRL, k << CTRL_RES_LSB);
			run0(1);
			chk("channel span", 41 - 2 * k, span);
			// lower resolutions are right-aligned, low bits dropped
			axi_rd(OFS_RESULT0);
			chk("result0", 32'hABC >> (2 * k), d);
		end
	endtask : t_res
	task automatic t_single();
		axi_wr(OFS_CHSEL0, 32'h00001005);
		run0(1);
		chk("scan len", 3, chs.size());
		chk("first ch", 0, chs[0]);
		chk("second ch", 2, chs[1]);
		chk("third ch", 12, chs[2]);
		axi_rd(OFS_RESULT0); chk("last ch", 12, d[20:16]);
		idle0(); chk("single stops", 0, h);
	endtask : t_single
	task automatic t_group();
		axi_wr(OFS_CHSEL0, 32'h00000002);
		axi_wr(OFS_GRPB0, 32'h00000008);
		axi_wr(OFS_CTRL, 32'h00000002);
		run0(1); chk("group a", 1, chs[0]);
		run0(1); chk("group b", 3, chs[0]);
	endtask : t_group
	task automatic t_cont();
		axi_wr(OFS_CHSEL0, 32'h00000001);
		axi_wr(OFS_CTRL, 32'h00000001);
		// the next pass starts with the third scan end, untriggered
		run0(3); chk("passes", 4, chs.size());
		axi_wr(OFS_CTRL, 32'h00000000);
		repeat (100) @(posedge CLOCK);
		idle0(); chk("cont stops", 0, h);
	endtask : t_cont
	task automatic t_interleave();
		// continuous on one timer shot, then single on a free-running timer
		for (int p = 0; p < 2; p++) begin
			axi_wr(OFS_CTRL, p ? 32'h00000050 : 32'h00000051);
			@(posedge CLOCK);
			start <= 1'b1;
			periodic <= p[0];
			@(posedge CLOCK);
			start <= 1'b0;
			repeat (400) @(posedge CLOCK);
			chk("pin link", 1, SHARED_PIN_LINK);
			chk("pair ch0", 2, CH_SEL_0);
			chk("pair ch1", 2, CH_SEL_1);
			chk("moved", 1, moved >= 6);
			chk("order", 0, order_err);
			axi_rd(OFS_RESULT1);
			chk("result1", 32'h00020123, d);
			periodic <= 1'b0;
			axi_wr(OFS_CTRL, 32'h00000000);
			repeat (200) @(posedge CLOCK);
		end
	endtask : t_interleave
	task automatic finish_test();
		$display("errors %0d checks %0d", error_cnt, checked);
		if (error_cnt == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : finish_test
	initial begin
		{RESET_N, start, periodic, S_AXI_AWVALID, S_AXI_WVALID} = '0;
		{S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = '0;
		{S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA} = '0;
		S_AXI_WSTRB = 4'hF;
		CODE_0 = 12'hABC;
		CODE_1 = 12'h123;
		error_cnt = 0;
		checked = 0;
		repeat (8) @(posedge CLOCK);
		RESET_N <= 1'b1;
		repeat (3) @(posedge CLOCK);
		t_regs();
		t_res();
		t_single();
		t_group();
		t_cont();
		t_interleave();
		finish_test();
	end
	initial begin
		#400000;
		error_cnt++;
		finish_test();
	end
endmodule : ilc_top_test
